// ===== common/sar_adc_pkg.sv
// Constants, types and state record for the converter and self-test block
package sar_adc_pkg;
    // Register map (byte addresses)
    localparam logic [8:0] OFS_CTRL = 9'h000;
    localparam logic [8:0] OFS_RESULT = 9'h004;
    localparam logic [8:0] OFS_STATUS = 9'h008;
    localparam logic [1:0] RAM_REGION = 2'h2;
    localparam int FLAG_BIT = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Conversion timing in machine cycles (one core_clk each)
    localparam logic [4:0] SAMPLE_LAST = 5'h04;
    localparam logic [4:0] CONV_LAST = 5'h1D;
    localparam logic [7:0] SAR_START = 8'h80;
    // Loader and self-test figures
    localparam logic [7:0] RAM_END = 8'h80;
    localparam logic [2:0] SETTLE_LAST = 3'h4;
    localparam logic [2:0] STRAP_LAST = 3'h4;
    localparam logic [2:0] CONV_WAIT_LAST = 3'h1;
    localparam logic [11:0] CAL_TARGET = 12'hFF0;
    localparam logic [11:0] FS_TARGET = 12'hFE8;
    localparam logic [7:0] FS_CODE = 8'hFF;
    localparam logic [11:0] LIN_STRIDE = 12'h010;
    localparam logic [7:0] LIN_LAST = 8'hFF;
    localparam logic [3:0] REF_LAST = 4'hF;

    typedef enum logic [4:0] {
        ST_BOOT = 5'h00, ST_USER = 5'h01, ST_LD_CLR = 5'h02,
        ST_LD_SETTLE = 5'h03, ST_LD_STORE = 5'h04, ST_LD_FALL = 5'h05,
        ST_RUN = 5'h06, ST_CAL_CHECK = 5'h07, ST_CAL_ZERO = 5'h08,
        ST_CAL_HOLD = 5'h09, ST_DAC_RUN = 5'h0A, ST_CONV = 5'h0B,
        ST_FS_CHECK = 5'h0C, ST_LIN_CHECK = 5'h0D, ST_PASS = 5'h0E,
        ST_FAIL = 5'h0F
    } seq_state_t;

    typedef struct packed {
        logic [8:0] awaddr; logic awvalid;
        logic [31:0] wdata; logic [3:0] wstrb; logic wvalid;
        logic bready;
        logic [8:0] araddr; logic arvalid;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready; logic wready;
        logic [1:0] bresp; logic bvalid;
        logic arready;
        logic [31:0] rdata; logic [1:0] rresp; logic rvalid;
    } axi_rsp_t;

    typedef struct packed {
        logic awDone; logic [8:0] awAddr;
        logic wDone; logic [7:0] wData; logic wStrb0;
        logic bValid; logic [1:0] bResp;
        logic rValid; logic [31:0] rData; logic [1:0] rResp;
        logic [4:0] mcCnt; logic [7:0] sar; logic [7:0] mask;
        logic [7:0] result; logic doneFlag; logic [2:0] chan;
        logic [2:0] syncIrq; logic irqF;
        logic [2:0][7:0] syncA; logic [7:0] aF;
        logic [2:0][1:0] syncC; logic [1:0] cF;
        seq_state_t st; seq_state_t ret; seq_state_t chk;
        logic [7:0] ptr; logic [1:0] loadNum; logic [2:0] waitCnt;
        logic [11:0] dacCnt; logic [11:0] dacTgt; logic [7:0] linStep;
        logic [3:0] refSel;
        logic pbAdv; logic pbClr; logic passN; logic failN;
        logic dacClr; logic dacAdv;
        logic [127:0][7:0] ram;
    } core_t;

    localparam core_t CORE_RESET = '{irqF: 1'b1, passN: 1'b1,
        failN: 1'b1, st: ST_BOOT, ret: ST_BOOT, chk: ST_BOOT,
        default: '0};
endpackage

// ===== rtl/sar_adc_control_selftest.sv
// Converter control, bootstrap loader and self-test sequencer
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module sar_adc_control_selftest (
    input wire logic core_clk,
    input wire logic rstn,
    input wire sar_adc_pkg::axi_req_t axiReq,
    output sar_adc_pkg::axi_rsp_t axiRsp,
    input wire logic cmpAbove,
    output logic [2:0] chanSel,
    output logic sampleEn,
    output logic [7:0] sarCode,
    input wire logic irqPin,
    input wire logic [7:0] portAIn,
    input wire logic [1:0] portCIn,
    output logic [5:0] portBOut,
    output logic [3:0] portCOut
);
    import sar_adc_pkg::*;

    core_t state_reg;
    core_t state_next;
    logic convDone;
    logic awHit;
    logic wHit;
    logic doWr;
    logic [8:0] wAddr;
    logic [7:0] wByte;
    logic wLane0;
    logic [31:0] rdMux;
    logic [1:0] rdResp;

    // Bus handshakes, one write and one read outstanding
    assign axiRsp.awready = !state_reg.awDone && !state_reg.bValid;
    assign axiRsp.wready = !state_reg.wDone && !state_reg.bValid;
    assign axiRsp.bvalid = state_reg.bValid;
    assign axiRsp.bresp = state_reg.bResp;
    assign axiRsp.arready = !state_reg.rValid;
    assign axiRsp.rvalid = state_reg.rValid;
    assign axiRsp.rdata = state_reg.rData;
    assign axiRsp.rresp = state_reg.rResp;

    // Analog side and port pins
    assign chanSel = state_reg.chan;
    assign sampleEn = (state_reg.mcCnt <= SAMPLE_LAST);
    assign sarCode = state_reg.sar;
    assign portBOut = {state_reg.dacAdv, state_reg.dacClr, state_reg.failN,
                       state_reg.passN, state_reg.pbClr, state_reg.pbAdv};
    assign portCOut = state_reg.refSel;

    // Write address and data may arrive in either order
    assign awHit = axiReq.awvalid && axiRsp.awready;
    assign wHit = axiReq.wvalid && axiRsp.wready;
    assign doWr = (state_reg.awDone || awHit) && (state_reg.wDone || wHit);
    assign wAddr = state_reg.awDone ? state_reg.awAddr : axiReq.awaddr;
    assign wByte = state_reg.wDone ? state_reg.wData : axiReq.wdata[7:0];
    assign wLane0 = state_reg.wDone ? state_reg.wStrb0 : axiReq.wstrb[0];
    assign convDone = (state_reg.mcCnt == CONV_LAST);

    // Read decode; the loaded RAM is visible four bytes per word
    always_comb begin
        rdMux = 32'h0000_0000;
        rdResp = RESP_OKAY;
        if (axiReq.araddr[8:7] == RAM_REGION) begin
            rdMux = {state_reg.ram[{axiReq.araddr[6:2], 2'h3}],
                     state_reg.ram[{axiReq.araddr[6:2], 2'h2}],
                     state_reg.ram[{axiReq.araddr[6:2], 2'h1}],
                     state_reg.ram[{axiReq.araddr[6:2], 2'h0}]};
        end else begin
            unique case (axiReq.araddr)
                OFS_CTRL: rdMux = {24'h00_0000, state_reg.doneFlag, 4'h0, state_reg.chan};
                OFS_RESULT: rdMux = {24'h00_0000, state_reg.result};
                OFS_STATUS: rdMux = {7'h00, state_reg.refSel, state_reg.dacCnt,
                                     state_reg.loadNum, state_reg.failN,
                                     state_reg.passN, state_reg.st};
                default: rdResp = RESP_DECERR;
            endcase
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        state_next = state_reg;

        // Pin synchronisers: a change counts when stages two and three agree
        state_next.syncIrq = {state_reg.syncIrq[1:0], irqPin};
        state_next.syncA = {state_reg.syncA[1:0], portAIn};
        state_next.syncC = {state_reg.syncC[1:0], portCIn};
        if (state_reg.syncIrq[1] == state_reg.syncIrq[2]) begin
            state_next.irqF = state_reg.syncIrq[2];
        end
        if (state_reg.syncA[1] == state_reg.syncA[2]) begin
            state_next.aF = state_reg.syncA[2];
        end
        if (state_reg.syncC[1] == state_reg.syncC[2]) begin
            state_next.cF = state_reg.syncC[2];
        end

        // Register bus: write side
        if (awHit) begin
            state_next.awDone = 1'b1;
            state_next.awAddr = axiReq.awaddr;
        end
        if (wHit) begin
            state_next.wDone = 1'b1;
            state_next.wData = axiReq.wdata[7:0];
            state_next.wStrb0 = axiReq.wstrb[0];
        end
        if (state_reg.bValid && axiReq.bready) begin
            state_next.bValid = 1'b0;
        end
        if (doWr) begin
            state_next.awDone = 1'b0;
            state_next.wDone = 1'b0;
            state_next.bValid = 1'b1;
            state_next.bResp = RESP_OKAY;
            if (wAddr == OFS_CTRL && wLane0) begin
                state_next.chan = wByte[2:0];
                state_next.doneFlag = 1'b0;
            end else if (wAddr != OFS_CTRL && wAddr != OFS_RESULT
                         && wAddr != OFS_STATUS && wAddr[8:7] != RAM_REGION) begin
                state_next.bResp = RESP_DECERR;
            end
        end

        // Register bus: read side
        if (state_reg.rValid && axiReq.rready) begin
            state_next.rValid = 1'b0;
        end
        if (axiReq.arvalid && axiRsp.arready) begin
            state_next.rValid = 1'b1;
            state_next.rData = rdMux;
            state_next.rResp = rdResp;
        end

        // Free-running 30-cycle conversion frame
        state_next.mcCnt = convDone ? 5'h00 : state_reg.mcCnt + 5'h01;
        if (state_reg.mcCnt == SAMPLE_LAST) begin
            state_next.sar = SAR_START;
            state_next.mask = SAR_START;
            state_next.doneFlag = 1'b0;
        end else if (state_reg.mask != 8'h00) begin
            // One trial per cycle, decided bit kept or dropped
            state_next.sar = (cmpAbove ? state_reg.sar : state_reg.sar & ~state_reg.mask)
                             | (state_reg.mask >> 1);
            state_next.mask = state_reg.mask >> 1;
        end
        // Result and flag land together; the set beats a same-cycle clear
        if (convDone) begin
            state_next.result = state_reg.sar;
            state_next.doneFlag = 1'b1;
        end

        // Loader and self-test sequencer
        unique case (state_reg.st)
            ST_BOOT: begin
                state_next.waitCnt = state_reg.waitCnt + 3'h1;
                if (state_reg.waitCnt == STRAP_LAST) begin
                    state_next.waitCnt = 3'h0;
                    if (!state_reg.irqF) begin
                        state_next.st = ST_LD_CLR;
                        state_next.pbClr = 1'b1;
                    end else begin
                        state_next.st = ST_USER;
                    end
                end
            end
            ST_USER, ST_PASS, ST_FAIL: begin
                state_next.st = state_reg.st;
            end
            ST_LD_CLR: begin
                state_next.pbClr = 1'b0;
                state_next.ptr = 8'h00;
                state_next.st = ST_LD_SETTLE;
            end
            ST_LD_SETTLE: begin
                state_next.waitCnt = state_reg.waitCnt + 3'h1;
                if (state_reg.waitCnt == SETTLE_LAST) begin
                    state_next.st = ST_LD_STORE;
                end
            end
            ST_LD_STORE: begin
                state_next.ram[state_reg.ptr[6:0]] = state_reg.aF;
                state_next.ptr = state_reg.ptr + 8'h01;
                state_next.pbAdv = 1'b1;
                state_next.st = ST_LD_FALL;
            end
            ST_LD_FALL: begin
                state_next.pbAdv = 1'b0;
                state_next.waitCnt = 3'h0;
                state_next.st = (state_reg.ptr == RAM_END) ? ST_RUN : ST_LD_SETTLE;
            end
            ST_RUN: begin
                // Every routine starts from a cleared stimulus counter
                state_next.loadNum = state_reg.loadNum + 2'h1;
                state_next.dacClr = 1'b1;
                state_next.dacCnt = 12'h000;
                state_next.ptr = 8'h00;
                state_next.waitCnt = 3'h0;
                state_next.ret = ST_CONV;
                unique case (state_reg.loadNum)
                    2'h0: begin
                        state_next.dacTgt = 12'h000;
                        state_next.ret = ST_CAL_CHECK;
                        state_next.st = ST_DAC_RUN;
                    end
                    2'h1: begin
                        state_next.dacTgt = FS_TARGET;
                        state_next.refSel = 4'h0;
                        state_next.chk = ST_FS_CHECK;
                        state_next.st = ST_DAC_RUN;
                    end
                    2'h2: begin
                        state_next.dacTgt = 12'h000;
                        state_next.linStep = 8'h00;
                        state_next.chk = ST_LIN_CHECK;
                        state_next.st = ST_DAC_RUN;
                    end
                    default: state_next.st = ST_FAIL;
                endcase
            end
            ST_CAL_CHECK: begin
                state_next.st = (state_reg.cF == 2'h0) ? ST_CAL_ZERO : ST_LD_SETTLE;
            end
            ST_CAL_ZERO: begin
                if (state_reg.cF[1]) begin
                    state_next.st = ST_LD_SETTLE;
                end else if (state_reg.cF[0]) begin
                    state_next.dacTgt = CAL_TARGET;
                    state_next.ret = ST_CAL_HOLD;
                    state_next.st = ST_DAC_RUN;
                end
            end
            ST_CAL_HOLD: begin
                if (state_reg.cF[1]) begin
                    state_next.st = ST_LD_SETTLE;
                end
            end
            ST_DAC_RUN: begin
                // Counter advances on the falling edge of each pulse
                state_next.dacClr = 1'b0;
                state_next.waitCnt = 3'h0;
                if (state_reg.dacAdv) begin
                    state_next.dacAdv = 1'b0;
                    state_next.dacCnt = state_reg.dacCnt + 12'h001;
                end else if (state_reg.dacCnt != state_reg.dacTgt) begin
                    state_next.dacAdv = 1'b1;
                end else begin
                    state_next.st = state_reg.ret;
                end
            end
            ST_CONV: begin
                // Second completion is the first one sampled wholly after the change
                if (convDone) begin
                    state_next.waitCnt = state_reg.waitCnt + 3'h1;
                    if (state_reg.waitCnt == CONV_WAIT_LAST) begin
                        state_next.st = state_reg.chk;
                    end
                end
            end
            ST_FS_CHECK: begin
                state_next.waitCnt = 3'h0;
                if (state_reg.result == FS_CODE) begin
                    state_next.st = ST_LD_SETTLE;
                end else if (state_reg.refSel == REF_LAST) begin
                    state_next.failN = 1'b0;
                    state_next.st = ST_FAIL;
                end else begin
                    state_next.refSel = state_reg.refSel + 4'h1;
                    state_next.st = ST_CONV;
                end
            end
            ST_LIN_CHECK: begin
                if (state_reg.result != state_reg.linStep) begin
                    state_next.failN = 1'b0;
                    state_next.st = ST_FAIL;
                end else if (state_reg.linStep == LIN_LAST) begin
                    state_next.passN = 1'b0;
                    state_next.st = ST_PASS;
                end else begin
                    state_next.linStep = state_reg.linStep + 8'h01;
                    state_next.dacTgt = state_reg.dacTgt + LIN_STRIDE;
                    state_next.ret = ST_CONV;
                    state_next.st = ST_DAC_RUN;
                end
            end
            default: state_next.st = ST_FAIL;
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_reg <= CORE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    AST_PERIOD: assert property (
        convDone |=> !convDone [*8] ##22 convDone)
        else $error("conversion period is not 30 cycles");
    AST_FLAG: assert property (
        convDone |=> state_reg.doneFlag && state_reg.result == $past(state_reg.sar))
        else $error("flag or result missing after completion");
    AST_START: assert property (
        state_reg.mcCnt == SAMPLE_LAST |=> state_reg.sar == 8'h80)
        else $error("search did not start at mid-range");
    AST_TRIAL: assert property (
        state_reg.mask != 8'h00 && state_reg.mcCnt > SAMPLE_LAST && !cmpAbove
        |=> (state_reg.sar & $past(state_reg.mask)) == 8'h00)
        else $error("trial bit kept while input below DAC");
    AST_EIGHT: assert property (
        state_reg.mcCnt == SAMPLE_LAST |=> ##8 state_reg.mask == 8'h00
        && state_reg.mcCnt == 5'h0D)
        else $error("search did not end after eight trials");
    AST_SAMPLE: assert property (
        $rose(sampleEn) |-> sampleEn [*5] ##1 !sampleEn [*8])
        else $error("sample window is not five cycles");
    AST_BOOT: assert property (
        state_reg.st == ST_BOOT && state_reg.waitCnt == STRAP_LAST
        |=> state_reg.st == ($past(state_reg.irqF) ? ST_USER : ST_LD_CLR))
        else $error("loader entered with interrupt pin high");
    AST_LOADEND: assert property (
        state_reg.st == ST_LD_FALL && state_reg.ptr == RAM_END |=> state_reg.st == ST_RUN)
        else $error("load did not end at pointer 80");
    AST_PASS: assert property (
        $fell(state_reg.passN) |-> state_reg.linStep == LIN_LAST && state_reg.failN)
        else $error("pass signalled before all steps checked");
    AST_FAIL: assert property (
        $past(state_reg.st) == ST_LIN_CHECK && $fell(state_reg.failN)
        |-> $past(state_reg.result) != $past(state_reg.linStep))
        else $error("fail signalled on a correct conversion");

endmodule // sar_adc_control_selftest

// ===== testbench/adc_fixture.sv
// Test fixture model: program memory, two counters, stimulus level, comparator
`timescale 1ns/1ps
module adc_fixture (
    input wire logic core_clk,
    input wire logic [5:0] portBOut,
    input wire logic [3:0] portCOut,
    input wire logic [7:0] sarCode,
    input wire logic sampleEn,
    input wire logic [7:0] romKey,
    input wire logic manEn,
    input wire logic [11:0] manLvl,
    input wire logic [11:0] faultAt,
    output logic [7:0] portAIn,
    output logic cmpAbove,
    output logic [11:0] dacCnt
);
    logic [11:0] memCnt = 12'h000;
    logic [5:0] pbLast = 6'h0C;
    logic [11:0] held = 12'h000;
    logic [11:0] dacQ = 12'h000;
    int gain;
    // Stimulus counter state, one driver
    assign dacCnt = dacQ;
    // Counters clear on a high level and count on a falling edge
    always @(posedge core_clk) begin
        pbLast <= portBOut;
        if (portBOut[1])
            memCnt <= 12'h000;
        else if (pbLast[0] && !portBOut[0])
            memCnt <= memCnt + 12'h001;
        if (portBOut[4])
            dacQ <= 12'h000;
        else if (pbLast[5] && !portBOut[5])
            dacQ <= dacQ + 12'h001;
        // Hold capacitor tracks the input while the sample switch is closed
        if (sampleEn)
            held <= manEn ? manLvl : dacCnt + ((dacCnt == faultAt) ? 12'h020 : 12'h000);
    end
    // Memory image; reference steps shift the gain near full scale
    assign portAIn = (memCnt[7:0] ^ romKey) + {6'h00, memCnt[9:8]};
    always_comb begin
        gain = (int'(held[11:8]) * (int'(portCOut) - 2)) / 4;
        cmpAbove = (int'(held) + 8 + gain) >= int'(sarCode) * 16;
    end
endmodule // adc_fixture

// ===== testbench/sar_adc_control_selftest_tb.sv
// Self-checking bench for the converter, loader and self-test sequencer
`timescale 1ns/1ps
module sar_adc_control_selftest_tb;
    import sar_adc_pkg::*;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    axi_req_t axiReq = '0;
    axi_rsp_t axiRsp;
    logic cmpAbove, sampleEn, irqPin = 1'b0, manEn = 1'b0;
    logic [2:0] chanSel;
    logic [7:0] sarCode, portAIn, romKey = 8'h00;
    logic [1:0] portCIn = 2'b00;
    logic [5:0] portBOut;
    logic [3:0] portCOut;
    logic [11:0] manLvl = 12'h000, faultAt = 12'hFFF, dacCnt;
    logic [31:0] rd, ex;
    note_t notes[$];
    note_t nt;
    int errTotal = 0, samplesChecked = 0, cyc = 0, i, k, j;
    // Machine-cycle clock
    initial forever #4 core_clk = ~core_clk;
    sar_adc_control_selftest dut_u (.core_clk(core_clk), .rstn(rstn), .axiReq(axiReq),
        .axiRsp(axiRsp), .cmpAbove(cmpAbove), .chanSel(chanSel), .sampleEn(sampleEn),
        .sarCode(sarCode), .irqPin(irqPin), .portAIn(portAIn), .portCIn(portCIn),
        .portBOut(portBOut), .portCOut(portCOut));
    adc_fixture fix_u (.core_clk(core_clk), .portBOut(portBOut), .portCOut(portCOut),
        .sarCode(sarCode), .sampleEn(sampleEn), .romKey(romKey), .manEn(manEn),
        .manLvl(manLvl), .faultAt(faultAt), .portAIn(portAIn), .cmpAbove(cmpAbove),
        .dacCnt(dacCnt));
    task automatic testDone();
        if (errTotal == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samplesChecked++;
        if (g !== e) begin
            errTotal++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One clock with a run-wide cycle limit
    task automatic step();
        @(posedge core_clk);
        cyc++;
        if (cyc > 99000) begin
            errTotal++;
            testDone();
        end
    endtask
    task automatic axi_wr(input logic [8:0] a, input logic [31:0] d, input logic [1:0] r);
        notes.push_back('{d: 32'h0, m: 32'h0, r: r});
        axiReq.awaddr <= a;
        axiReq.awvalid <= 1'b1;
        axiReq.wdata <= d;
        axiReq.wstrb <= 4'hF;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b1;
        do begin
            step();
            if (axiRsp.awready === 1'b1)
                axiReq.awvalid <= 1'b0;
            if (axiRsp.wready === 1'b1)
                axiReq.wvalid <= 1'b0;
        end while (axiRsp.bvalid !== 1'b1);
        axiReq.bready <= 1'b0;
        step();
    endtask
    task automatic axi_rd(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m,
            input logic [1:0] r);
        notes.push_back('{d: e, m: m, r: r});
        axiReq.araddr <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b1;
        do begin
            step();
            if (axiRsp.arready === 1'b1)
                axiReq.arvalid <= 1'b0;
        end while (axiRsp.rvalid !== 1'b1);
        rd = axiRsp.rdata;
        axiReq.rready <= 1'b0;
        step();
    endtask
    // Each bus answer is matched against the oldest note
    always @(posedge core_clk) begin
        if ((axiRsp.bvalid & axiReq.bready) === 1'b1 || (axiRsp.rvalid & axiReq.rready) === 1'b1) begin
            nt = notes.pop_front();
            chk("resp", {30'h0, nt.r}, {30'h0, axiRsp.bvalid ? axiRsp.bresp : axiRsp.rresp});
            chk("rdata", nt.d & nt.m, axiRsp.rdata & nt.m);
        end
    end
    task automatic wait_se(input logic v);
        do step(); while (sampleEn !== v);
    endtask
    task automatic reset_run(input logic irq, input logic [1:0] pc, input logic [11:0] f);
        rstn <= 1'b0;
        irqPin <= irq;
        portCIn <= pc;
        faultAt <= f;
        repeat (20) step();
        rstn <= 1'b1;
        repeat (20) step();
    endtask
    function automatic logic [7:0] rom(input logic [11:0] a);
        return (a[7:0] ^ romKey) + {6'h00, a[9:8]};
    endfunction
    // Main sequence: user mode, passing self-test, failing self-test
    initial begin
        void'($urandom(32'h5DF08137));
        reset_run(1'b1, 2'b11, 12'hFFF);
        axi_rd(OFS_STATUS, {27'h0, ST_USER}, 32'h1F, RESP_OKAY);
        chk("portB", 32'h0C, {26'h0, portBOut});
        wait_se(1'b0);
        wait_se(1'b1);
        for (k = 0; sampleEn === 1'b1; k++)
            step();
        chk("sarStart", {24'h0, SAR_START}, {24'h0, sarCode});
        chk("sampleLen", 5, k);
        for (j = k; sampleEn !== 1'b1; j++)
            step();
        chk("period", 30, j);
        for (i = 0; i < 8; i++) begin
            k = $urandom_range(255);
            axi_wr(OFS_CTRL, i, RESP_OKAY);
            chk("chanSel", i, {29'h0, chanSel});
            manLvl <= {k[7:0], 4'h0};
            manEn <= 1'b1;
            repeat (2) begin
                wait_se(1'b0);
                wait_se(1'b1);
            end
            axi_rd(OFS_CTRL, 32'h80 | i, 32'h87, RESP_OKAY);
            axi_rd(OFS_RESULT, k, 32'hFF, RESP_OKAY);
        end
        // Control write before the search start must clear the fresh flag
        wait_se(1'b0);
        wait_se(1'b1);
        axi_wr(OFS_CTRL, 32'h3, RESP_OKAY);
        axi_rd(OFS_CTRL, 32'h03, 32'h87, RESP_OKAY);
        axi_wr(OFS_RESULT, 32'h0, RESP_OKAY);
        axi_rd(OFS_RESULT, k, 32'hFF, RESP_OKAY);
        axi_rd(9'h00C, 32'h0, 32'h0, RESP_DECERR);
        romKey <= 8'($urandom);
        manEn <= 1'b0;
        reset_run(1'b0, 2'b00, 12'hFFF);
        do axi_rd(OFS_STATUS, 32'h0, 32'h0, RESP_OKAY); while (rd[4:0] !== ST_CAL_ZERO);
        portCIn <= 2'b01;
        do step(); while (dacCnt !== CAL_TARGET);
        repeat (100) step();
        chk("calHold", {20'h0, CAL_TARGET}, {20'h0, dacCnt});
        portCIn <= 2'b11;
        do step(); while (portBOut[3:2] === 2'b11);
        chk("verdict", 32'h2, {30'h0, portBOut[3:2]});
        chk("refSel", 32'h2, {28'h0, portCOut});
        chk("dacEnd", {20'h0, LIN_LAST, 4'h0}, {20'h0, dacCnt});
        axi_rd(OFS_STATUS, {23'h0, 2'h3, 1'b1, 1'b0, ST_PASS}, 32'h1FF, RESP_OKAY);
        for (i = 0; i < 32; i++) begin
            for (j = 0; j < 4; j++)
                ex[8 * j +: 8] = rom(12'(256 + 4 * i + j));
            axi_rd(9'(256 + 4 * i), ex, 32'hFFFFFFFF, RESP_OKAY);
        end
        k = $urandom_range(60, 1);
        reset_run(1'b0, 2'b11, {k[7:0], 4'h0});
        do step(); while (dacCnt !== FS_TARGET);
        chk("refOff", 32'h0, {28'h0, portCOut});
        do step(); while (portBOut[3:2] === 2'b11);
        chk("verdict", 32'h1, {30'h0, portBOut[3:2]});
        chk("dacStop", {20'h0, k[7:0], 4'h0}, {20'h0, dacCnt});
        testDone();
    end
endmodule // sar_adc_control_selftest_tb
